// file: rtl/ccs_charge_cycle_supervisor.v
`include "ccs_regs.vh"
module ccs_charge_cycle_supervisor #(
    parameter [31:0] TICK_CYCLES = `CCS_TICK_CYCLES
) (
    input wire clk,
    input wire reset,
    input wire clk_en,
    input wire adc_valid,
    input wire [2:0] adc_channel,
    input wire [15:0] adc_raw,
    input wire [2:0] result_sel,
    output reg [15:0] result_data,
    input wire [15:0] vbat_mv,
    input wire [15:0] ibat_ma,
    input wire [15:0] tdie_half_c,
    input wire [15:0] trickle_thr_mv,
    input wire [15:0] precharge_thr_mv,
    input wire [15:0] cv_thr_mv,
    input wire [15:0] recharge_thr_mv,
    input wire [15:0] term_current_ma,
    input wire [15:0] treg_thr_half_c,
    input wire src1_valid,
    input wire src2_valid,
    input wire host_src_sel_we,
    input wire host_src_sel,
    input wire cfg_we,
    input wire cfg_chg_en,
    input wire [1:0] cfg_topoff_sel,
    input wire [1:0] fast_charge_timer_sel,
    input wire precharge_timer_sel,
    input wire input_high_impedance_en,
    input wire otg_req,
    input wire [11:0] otg_code,
    input wire wdt_kick,
    input wire reg_reset,
    input wire fault_clear,
    output reg [2:0] charge_status,
    output reg charge_on,
    output reg current_reduce,
    output reg power_good_out,
    output reg host_alert,
    output reg timer_fault,
    output reg src_active,
    output reg src1_on,
    output reg src2_on,
    output reg otg_on,
    output reg [11:0] otg_setpoint,
    output reg wdt_expired,
    output reg chg_en,
    output reg [1:0] topoff_sel,
    output reg [1:0] fast_sel,
    output reg precharge_sel
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_TRICKLE = 3'h1;
    localparam [2:0] ST_PRECHG = 3'h2;
    localparam [2:0] ST_CC = 3'h3;
    localparam [2:0] ST_CV = 3'h4;
    localparam [2:0] ST_TOPOFF = 3'h5;
    localparam [2:0] ST_DONE = 3'h6;
    localparam [2:0] ST_FAULT = 3'h7;

    // Timers count millisecond ticks, so the longest 24 hour limit fits 27 bits.
    function [26:0] hr_ms;
        input [31:0] hr;
        reg [31:0] t;
        begin
            t = hr * 32'd3600000;
            hr_ms = t[26:0];
        end
    endfunction
    function [26:0] min_ms;
        input [31:0] mins;
        reg [31:0] t;
        begin
            t = mins * 32'd60000;
            min_ms = t[26:0];
        end
    endfunction
    function [15:0] clamp16;
        input [15:0] v;
        input [15:0] lim;
        begin
            clamp16 = (v > lim) ? lim : v;
        end
    endfunction

    reg [2:0] state;
    reg [2:0] next_state;
    reg [31:0] tick_cnt;
    reg tick;
    reg [26:0] phase_ms;
    reg [26:0] wdt_ms;
    reg [26:0] phase_limit;
    reg phase_expire;
    reg [15:0] scaled;
    wire [15:0] mem_rdata;
    wire cfg_defaults;

    // Millisecond tick keeps every timer narrow instead of counting raw cycles.
    always @(posedge clk) begin
        if (reset) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else if (clk_en) begin
            tick <= (tick_cnt == TICK_CYCLES - 32'h1);
            tick_cnt <= (tick_cnt == TICK_CYCLES - 32'h1) ? 32'h0 : tick_cnt + 32'h1;
        end
    end

    // Monitor results are clipped to the full scale of each channel except VIN, which is stored unclipped.
    always @* begin
        case (adc_channel)
            `CCS_CH_VBAT: scaled = clamp16(adc_raw, `CCS_VBAT_MAX_MV);
            `CCS_CH_VSYS: scaled = clamp16(adc_raw, `CCS_VSYS_MAX_MV);
            `CCS_CH_IBAT: scaled = clamp16(adc_raw, `CCS_IBAT_MAX_MA);
            `CCS_CH_TS: scaled = clamp16(adc_raw, `CCS_TS_MAX_CODE);
            `CCS_CH_TDIE: begin
                if ($signed(adc_raw) < $signed(`CCS_TDIE_MIN_HALF)) begin
                    scaled = `CCS_TDIE_MIN_HALF;
                end else if ($signed(adc_raw) > $signed(`CCS_TDIE_MAX_HALF)) begin
                    scaled = `CCS_TDIE_MAX_HALF;
                end else begin
                    scaled = adc_raw;
                end
            end
            default: scaled = adc_raw;
        endcase
    end

    ccs_result_mem u_mem (
        .clk(clk),
        .clk_en(clk_en),
        .we(adc_valid),
        .waddr(adc_channel),
        .wdata(scaled),
        .raddr(result_sel),
        .rdata(mem_rdata)
    );

    always @(posedge clk) begin
        if (reset) begin
            result_data <= 16'h0;
        end else if (clk_en) begin
            result_data <= mem_rdata;
        end
    end

    // Watchdog uses the nominal 160 s so expiry is never before either minimum.
    always @(posedge clk) begin
        if (reset) begin
            wdt_ms <= 27'h0;
            wdt_expired <= 1'b0;
        end else if (clk_en) begin
            wdt_expired <= 1'b0;
            if (wdt_kick) begin
                wdt_ms <= 27'h0;
            end else if (tick) begin
                if (wdt_ms == min_ms(`CCS_WDT_S) / 27'd60 * 27'd1 - 27'h1) begin
                    wdt_ms <= 27'h0;
                    wdt_expired <= 1'b1;
                end else begin
                    wdt_ms <= wdt_ms + 27'h1;
                end
            end
        end
    end

    assign cfg_defaults = wdt_expired | reg_reset;
    // Defaults outrank a host write in the same cycle, so a stale write cannot survive a reset.
    always @(posedge clk) begin
        if (reset || (clk_en && cfg_defaults)) begin
            chg_en <= `CCS_DEF_CHG_EN;
            topoff_sel <= `CCS_DEF_TOPOFF_SEL;
            fast_sel <= `CCS_DEF_FAST_SEL;
            precharge_sel <= `CCS_DEF_PRECHG_SEL;
            otg_setpoint <= `CCS_OTG_MIN_CODE;
        end else if (clk_en && cfg_we) begin
            chg_en <= cfg_chg_en;
            topoff_sel <= (cfg_topoff_sel == 2'h3) ? topoff_sel : cfg_topoff_sel;
            fast_sel <= fast_charge_timer_sel;
            precharge_sel <= precharge_timer_sel;
            if (otg_code >= `CCS_OTG_MIN_CODE && otg_code <= `CCS_OTG_MAX_CODE) begin
                otg_setpoint <= otg_code;
            end
        end
    end

    // Phase limits in milliseconds.
    always @* begin
        case (state)
            ST_TRICKLE: phase_limit = hr_ms(`CCS_TRICKLE_HR);
            ST_PRECHG: phase_limit = precharge_sel ? hr_ms(`CCS_PRECHG_HR) : hr_ms(`CCS_TRICKLE_HR);
            ST_CC, ST_CV: begin
                case (fast_sel)
                    2'h0: phase_limit = hr_ms(`CCS_FAST_5_HR);
                    2'h1: phase_limit = hr_ms(`CCS_FAST_8_HR);
                    2'h2: phase_limit = hr_ms(`CCS_FAST_12_HR);
                    default: phase_limit = hr_ms(`CCS_FAST_24_HR);
                endcase
            end
            ST_TOPOFF: begin
                case (topoff_sel)
                    2'h0: phase_limit = min_ms(`CCS_TOPOFF_15_MIN);
                    2'h1: phase_limit = min_ms(`CCS_TOPOFF_30_MIN);
                    default: phase_limit = min_ms(`CCS_TOPOFF_45_MIN);
                endcase
            end
            default: phase_limit = 27'h7ffffff;
        endcase
        phase_expire = tick && (phase_ms >= phase_limit - 27'h1);
    end

    // Phase selection from battery voltage, charge current in CV and the phase timers.
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (chg_en && src_active) begin
                    if (vbat_mv < trickle_thr_mv) next_state = ST_TRICKLE;
                    else if (vbat_mv < precharge_thr_mv) next_state = ST_PRECHG;
                    else if (vbat_mv < cv_thr_mv) next_state = ST_CC;
                    else next_state = ST_CV;
                end
            end
            ST_TRICKLE: begin
                if (phase_expire) next_state = ST_FAULT;
                else if (vbat_mv >= trickle_thr_mv) next_state = ST_PRECHG;
            end
            ST_PRECHG: begin
                if (phase_expire) next_state = ST_FAULT;
                else if (vbat_mv >= precharge_thr_mv) next_state = ST_CC;
            end
            ST_CC: begin
                if (phase_expire) next_state = ST_FAULT;
                else if (vbat_mv >= cv_thr_mv) next_state = ST_CV;
            end
            ST_CV: begin
                if (phase_expire) next_state = ST_FAULT;
                else if (ibat_ma < term_current_ma) next_state = ST_TOPOFF;
            end
            ST_TOPOFF: if (phase_expire) next_state = ST_DONE;
            ST_DONE: if (vbat_mv < recharge_thr_mv) next_state = ST_IDLE;
            ST_FAULT: if (fault_clear) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
        if (!chg_en || !src_active) begin
            if (state != ST_FAULT) next_state = ST_IDLE;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
            phase_ms <= 27'h0;
            timer_fault <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            if (next_state != state) begin
                phase_ms <= 27'h0;
            end else if (tick) begin
                phase_ms <= phase_ms + 27'h1;
            end
            // A new expiry outranks a clear in the same cycle.
            if (state != ST_TOPOFF && phase_expire && next_state == ST_FAULT) begin
                timer_fault <= 1'b1;
            end else if (fault_clear) begin
                timer_fault <= 1'b0;
            end
        end
    end

    // Source arbitration holds the first arrival until it leaves or the host moves it.
    always @(posedge clk) begin
        if (reset) begin
            src1_on <= 1'b0;
            src2_on <= 1'b0;
        end else if (clk_en) begin
            if (host_src_sel_we) begin
                src1_on <= !host_src_sel && src1_valid;
                src2_on <= host_src_sel && src2_valid;
            end else begin
                if (src1_on && !src1_valid) src1_on <= 1'b0;
                if (src2_on && !src2_valid) src2_on <= 1'b0;
                if (!src1_on && !src2_on) begin
                    if (src1_valid) src1_on <= 1'b1;
                    else if (src2_valid) src2_on <= 1'b1;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            charge_status <= `CCS_STAT_IDLE;
            charge_on <= 1'b0;
            current_reduce <= 1'b0;
            power_good_out <= 1'b0;
            host_alert <= 1'b0;
            src_active <= 1'b0;
            otg_on <= 1'b0;
        end else if (clk_en) begin
            charge_status <= next_state;
            charge_on <= next_state != ST_IDLE && next_state != ST_DONE && next_state != ST_FAULT;
            current_reduce <= $signed(tdie_half_c) > $signed(treg_thr_half_c);
            power_good_out <= src1_valid | src2_valid;
            src_active <= src1_valid | src2_valid;
            host_alert <= next_state == ST_FAULT;
            otg_on <= otg_req && !(src1_valid | src2_valid);
        end
    end
endmodule // ccs_charge_cycle_supervisor

// file: rtl/ccs_regs.vh
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
// Clock and time bases.
`define CCS_CLK_HZ 125000000
`define CCS_TICK_MS 1
`define CCS_TICK_CYCLES ((`CCS_CLK_HZ / 1000) * `CCS_TICK_MS)
// Timer durations in minutes, hours and seconds, nominal.
`define CCS_TOPOFF_15_MIN 15
`define CCS_TOPOFF_30_MIN 30
`define CCS_TOPOFF_45_MIN 45
`define CCS_TRICKLE_HR 1
`define CCS_PRECHG_HR 2
`define CCS_FAST_5_HR 5
`define CCS_FAST_8_HR 8
`define CCS_FAST_12_HR 12
`define CCS_FAST_24_HR 24
`define CCS_WDT_S 160
`define CCS_WDT_HIZ_MIN_S 100
`define CCS_WDT_MIN_S 136
// Monitor ranges in result units.
`define CCS_VBAT_MAX_MV 16'h4e20
`define CCS_VSYS_MAX_MV 16'h5dc0
`define CCS_IBAT_MAX_MA 16'h1f40
`define CCS_TS_MAX_CODE 16'h03ff
`define CCS_TDIE_MIN_HALF 16'hffb0
`define CCS_TDIE_MAX_HALF 16'h012c
// Result channel indices.
`define CCS_CH_IBAT 3'h0
`define CCS_CH_VIN 3'h1
`define CCS_CH_VBAT 3'h2
`define CCS_CH_VSYS 3'h3
`define CCS_CH_TS 3'h4
`define CCS_CH_TDIE 3'h5
// Reset defaults of the configuration state.
`define CCS_DEF_CHG_EN 1'b1
`define CCS_DEF_TOPOFF_SEL 2'h0
`define CCS_DEF_FAST_SEL 2'h2
`define CCS_DEF_PRECHG_SEL 1'b1
// Charge status codes.
`define CCS_STAT_IDLE 3'h0
`define CCS_STAT_TRICKLE 3'h1
`define CCS_STAT_PRECHG 3'h2
`define CCS_STAT_CC 3'h3
`define CCS_STAT_CV 3'h4
`define CCS_STAT_TOPOFF 3'h5
`define CCS_STAT_DONE 3'h6
`define CCS_STAT_FAULT 3'h7
// OTG output range in 10 mV steps.
`define CCS_OTG_MIN_CODE 12'h118
`define CCS_OTG_MAX_CODE 12'h898
`endif

// file: rtl/ccs_result_mem.v
module ccs_result_mem (
    input wire clk,
    input wire clk_en,
    input wire we,
    input wire [2:0] waddr,
    input wire [15:0] wdata,
    input wire [2:0] raddr,
    output reg [15:0] rdata
);
    reg [15:0] mem [0:7];
    always @(posedge clk) begin
        if (clk_en) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule // ccs_result_mem

// file: dv/ccs_props.sv
module ccs_props (
    input wire clk,
    input wire reset,
    input wire clk_en,
    input wire src1_valid,
    input wire src2_valid,
    input wire [15:0] tdie_half_c,
    input wire [15:0] treg_thr_half_c,
    input wire reg_reset,
    input wire fault_clear,
    input wire [2:0] charge_status,
    input wire charge_on,
    input wire current_reduce,
    input wire power_good_out,
    input wire host_alert,
    input wire timer_fault,
    input wire src1_on,
    input wire src2_on,
    input wire otg_on,
    input wire [11:0] otg_setpoint,
    input wire chg_en,
    input wire [1:0] topoff_sel,
    input wire [1:0] fast_sel,
    input wire precharge_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    wire any_src = src1_valid || src2_valid;
    // Signed compare, so a cold die below zero never reads as hot.
    wire hot = $signed(tdie_half_c) > $signed(treg_thr_half_c);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    a_pg_source: assert property (!$past(reset) && $past(clk_en) |-> power_good_out == $past(any_src))
        else $error("power good does not follow source");
    a_alert_fault: assert property (host_alert == (charge_status == 3'h7))
        else $error("host alert differs from fault state");
    a_src_single: assert property (!(src1_on && src2_on))
        else $error("both sources on");
    a_otg_nosrc: assert property (otg_on |-> !power_good_out)
        else $error("otg on with input present");
    a_otg_range: assert property (otg_setpoint >= 12'h118 && otg_setpoint <= 12'h898)
        else $error("otg setpoint out of range");
    a_reg_defaults: assert property (reg_reset && clk_en |=> chg_en && precharge_sel &&
        topoff_sel == 2'h0 && fast_sel == 2'h2)
        else $error("defaults not restored");
    a_fault_hold: assert property (timer_fault && !fault_clear |=> timer_fault)
        else $error("timer fault dropped");
    a_idle_off: assert property (charge_status inside {3'h0, 3'h6, 3'h7} |-> !charge_on)
        else $error("charging while idle, done or faulted");
    a_reduce_temp: assert property (!$past(reset) && $past(clk_en) |-> current_reduce == $past(hot))
        else $error("current reduce wrong");
    a_enable_freeze: assert property (!$past(reset) && !$past(clk_en) |-> $stable(charge_status) &&
        $stable(current_reduce) && $stable(power_good_out))
        else $error("state moved while clock enable low");
    c_cv: cover property (charge_status == 3'h4);
    c_reduce: cover property (current_reduce);
    c_otg: cover property (otg_on);
endmodule // ccs_props

bind ccs_charge_cycle_supervisor ccs_props ccs_props_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
    .src1_valid(src1_valid), .src2_valid(src2_valid), .tdie_half_c(tdie_half_c), .treg_thr_half_c(treg_thr_half_c),
    .reg_reset(reg_reset), .fault_clear(fault_clear), .charge_status(charge_status), .charge_on(charge_on),
    .current_reduce(current_reduce),
    .power_good_out(power_good_out), .host_alert(host_alert), .timer_fault(timer_fault), .src1_on(src1_on),
    .src2_on(src2_on), .otg_on(otg_on), .otg_setpoint(otg_setpoint), .chg_en(chg_en), .topoff_sel(topoff_sel),
    .fast_sel(fast_sel), .precharge_sel(precharge_sel));

// file: dv/ccs_battery_model.sv
module ccs_battery_model (
    input wire clk,
    input wire charge_on,
    input wire [15:0] cell_mv,
    input wire [15:0] draw_ma,
    output logic [15:0] vbat_mv,
    output logic [15:0] ibat_ma
);
    timeunit 1ns;
    timeprecision 1ps;
    // A cell only takes current while it is being charged; sensing lags one cycle like a real monitor.
    always @(posedge clk) begin
        vbat_mv <= cell_mv;
        ibat_ma <= charge_on ? draw_ma : 16'h0000;
    end
endmodule // ccs_battery_model

// file: dv/ccs_charge_cycle_supervisor_bench.sv
module ccs_charge_cycle_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, adc_valid = 1'b0, src1_valid = 1'b0, src2_valid = 1'b0;
    logic host_src_sel_we = 1'b0, host_src_sel = 1'b0, cfg_we = 1'b0, cfg_chg_en = 1'b1, precharge_timer_sel = 1'b1;
    logic otg_req = 1'b0, wdt_kick = 1'b0, reg_reset = 1'b0, fault_clear = 1'b0, charge_on;
    logic [2:0] adc_channel = 3'h0, result_sel = 3'h0, charge_status;
    logic [1:0] cfg_topoff_sel = 2'h0, fast_charge_timer_sel = 2'h2, topoff_sel, fast_sel;
    logic [11:0] otg_code = 12'h118, otg_setpoint;
    logic [15:0] adc_raw = 16'h0, cell_mv = 16'h03e8, draw_ma = 16'h01f4, tdie_half_c = 16'h0, cv_thr_mv = 16'h1068;
    logic [15:0] term_current_ma = 16'h0, treg_thr_half_c = 16'h00b4, vbat_mv, ibat_ma, result_data;
    logic current_reduce, power_good_out, host_alert, timer_fault, src1_on, src2_on, otg_on, chg_en, precharge_sel;
    logic clk_en = 1'b1, src_active, wdt_expired;
    int fail_count = 0;
    int checked = 0;
    logic [2:0] ach [7] = '{3'h2, 3'h2, 3'h3, 3'h0, 3'h4, 3'h5, 3'h5};
    logic [15:0] araw [7] = '{16'hffff, 16'h1234, 16'hffff, 16'hffff, 16'hffff, 16'hff00, 16'h0200};
    logic [15:0] aexp [7] = '{16'h4e20, 16'h1234, 16'h5dc0, 16'h1f40, 16'h03ff, 16'hffb0, 16'h012c};

    always #4 clk = ~clk;

    ccs_battery_model ccs_battery_model_inst (.clk(clk), .charge_on(charge_on), .cell_mv(cell_mv),
        .draw_ma(draw_ma), .vbat_mv(vbat_mv), .ibat_ma(ibat_ma));

    ccs_charge_cycle_supervisor #(.TICK_CYCLES(32'd2)) ccs_charge_cycle_supervisor_inst (.clk(clk), .reset(reset),
        .clk_en(clk_en), .adc_valid(adc_valid), .adc_channel(adc_channel), .adc_raw(adc_raw),
        .result_sel(result_sel),
        .result_data(result_data), .vbat_mv(vbat_mv), .ibat_ma(ibat_ma), .tdie_half_c(tdie_half_c),
        .trickle_thr_mv(16'h07d0), .precharge_thr_mv(16'h0bb8), .cv_thr_mv(cv_thr_mv), .recharge_thr_mv(16'h0ed8),
        .term_current_ma(term_current_ma), .treg_thr_half_c(treg_thr_half_c), .src1_valid(src1_valid),
        .src2_valid(src2_valid), .host_src_sel_we(host_src_sel_we), .host_src_sel(host_src_sel), .cfg_we(cfg_we),
        .cfg_chg_en(cfg_chg_en), .cfg_topoff_sel(cfg_topoff_sel), .fast_charge_timer_sel(fast_charge_timer_sel),
        .precharge_timer_sel(precharge_timer_sel), .input_high_impedance_en(1'b0), .otg_req(otg_req),
        .otg_code(otg_code), .wdt_kick(wdt_kick), .reg_reset(reg_reset), .fault_clear(fault_clear),
        .charge_status(charge_status), .charge_on(charge_on), .current_reduce(current_reduce),
        .power_good_out(power_good_out), .host_alert(host_alert), .timer_fault(timer_fault), .src_active(src_active),
        .src1_on(src1_on), .src2_on(src2_on), .otg_on(otg_on), .otg_setpoint(otg_setpoint), .wdt_expired(wdt_expired),
        .chg_en(chg_en), .topoff_sel(topoff_sel), .fast_sel(fast_sel), .precharge_sel(precharge_sel));

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic adc_chk(input logic [2:0] ch, input logic [15:0] raw, input logic [15:0] exp);
        adc_channel = ch;
        adc_raw = raw;
        adc_valid = 1'b1;
        step(1);
        adc_valid = 1'b0;
        result_sel = ch;
        step(3);
        chk(result_data, exp);
    endtask

    task automatic cfg(input logic en, input logic [1:0] top, input logic [1:0] fast, input logic [11:0] otg);
        {cfg_chg_en, cfg_topoff_sel, fast_charge_timer_sel, otg_code} = {en, top, fast, otg};
        precharge_timer_sel = ~precharge_timer_sel;
        cfg_we = 1'b1;
        step(1);
        cfg_we = 1'b0;
        step(1);
    endtask

    task automatic wait_status(input logic [2:0] exp);
        int i;
        for (i = 0; i < 20 && charge_status !== exp; i++) step(1);
        chk({13'h0, charge_status}, {13'h0, exp});
    endtask

    initial begin
        step(8);
        chk({10'h0, chg_en, topoff_sel, fast_sel, precharge_sel}, 16'h0025);
        chk({4'h0, otg_setpoint}, 16'h0118);
        reset = 1'b0;
        step(1);
        for (int k = 0; k < 7; k++) adc_chk(ach[k], araw[k], aexp[k]);
        src1_valid = 1'b1;
        step(2);
        chk({13'h0, charge_status}, 16'h0001);
        chk({14'h0, power_good_out, src1_on}, 16'h0003);
        chk({14'h0, src_active, wdt_expired}, 16'h0002);
        src2_valid = 1'b1;
        step(2);
        chk({14'h0, src1_on, src2_on}, 16'h0002);
        host_src_sel = 1'b1;
        host_src_sel_we = 1'b1;
        step(1);
        host_src_sel_we = 1'b0;
        step(1);
        chk({14'h0, src1_on, src2_on}, 16'h0001);
        cell_mv = 16'h09c4;
        wait_status(3'h2);
        cell_mv = 16'h0dac;
        wait_status(3'h3);
        cv_thr_mv = 16'h0fa0;
        cell_mv = 16'h1004;
        wait_status(3'h4);
        term_current_ma = 16'h0064;
        draw_ma = 16'h0032;
        wait_status(3'h5);
        tdie_half_c = 16'h00c8;
        step(2);
        chk({15'h0, current_reduce}, 16'h0001);
        tdie_half_c = 16'hff9c;
        step(2);
        chk({15'h0, current_reduce}, 16'h0000);
        clk_en = 1'b0;
        tdie_half_c = 16'h00c8;
        step(3);
        chk({12'h0, current_reduce, charge_status}, 16'h0005);
        clk_en = 1'b1;
        step(2);
        chk({12'h0, current_reduce, charge_status}, 16'h000d);
        tdie_half_c = 16'hff9c;
        cfg(1'b0, 2'h1, 2'h3, 12'h898);
        chk({10'h0, chg_en, topoff_sel, fast_sel, precharge_sel}, 16'h000e);
        chk({4'h0, otg_setpoint}, 16'h0898);
        wait_status(3'h0);
        for (int k = 0; k < 4; k++) begin
            cfg(1'b1, k[1:0], k[1:0], 12'h117);
            chk({14'h0, fast_sel}, 16'(k));
            chk({14'h0, topoff_sel}, (k == 3) ? 16'h0002 : 16'(k));
        end
        chk({4'h0, otg_setpoint}, 16'h0898);
        cfg(1'b0, 2'h1, 2'h1, 12'h898);
        wait_status(3'h0);
        // The monitor lags one cycle on entry to CV, so a nonzero termination level would end the cycle at once.
        term_current_ma = 16'h0000;
        draw_ma = 16'h01f4;
        reg_reset = 1'b1;
        step(1);
        reg_reset = 1'b0;
        step(1);
        chk({10'h0, chg_en, topoff_sel, fast_sel, precharge_sel}, 16'h0025);
        wait_status(3'h4);
        src1_valid = 1'b0;
        src2_valid = 1'b0;
        otg_req = 1'b1;
        step(3);
        chk({13'h0, power_good_out, otg_on, charge_status == 3'h0}, 16'h0003);
        src1_valid = 1'b1;
        step(3);
        chk({15'h0, otg_on}, 16'h0000);
        wdt_kick = 1'b1;
        fault_clear = 1'b1;
        step(1);
        wdt_kick = 1'b0;
        fault_clear = 1'b0;
        step(1);
        chk({14'h0, timer_fault, host_alert}, 16'h0000);
        conclude;
    end

    // The tests take under a hundred cycles; this span of 12500 cycles leaves wide margin.
    initial begin
        #100000;
        fail_count++;
        conclude;
    end
endmodule // ccs_charge_cycle_supervisor_bench
